// ===== core/umd_pkg.sv
/*
  Constants for the unified memory map decoder: region bounds, variant codes,
  and target codes.
  Assumes a 16-bit unified address space shared by CPU and DMA.
*/
package umd_pkg;

  // ==========================================================================
  // Variants
  localparam logic [1:0] UMD_VAR_SMALL = 2'h0;
  localparam logic [1:0] UMD_VAR_MID = 2'h1;
  localparam logic [1:0] UMD_VAR_LARGE = 2'h2;

  // ==========================================================================
  // Region bounds
  localparam logic [15:0] UMD_FLASH_END_SMALL = 16'h1FFF;
  localparam logic [15:0] UMD_FLASH_END_MID = 16'h3FFF;
  localparam logic [15:0] UMD_FLASH_END_LARGE = 16'h7FFF;
  localparam logic [15:0] UMD_SRAM_BASE = 16'hF000;
  localparam logic [15:0] UMD_HOLE_LO_SMALL = 16'hF300;
  localparam logic [15:0] UMD_HOLE_LO_MID = 16'hF700;
  localparam logic [15:0] UMD_HOLE_HI = 16'hFEFF;
  localparam logic [15:0] UMD_VOLATILE_LO = 16'hFDA2;
  localparam logic [15:0] UMD_VOLATILE_HI = 16'hFEFF;
  localparam logic [15:0] UMD_DATA_LO = 16'hFF00;
  localparam logic [15:0] UMD_DATA_HI = 16'hFFFF;
  localparam logic [15:0] UMD_RADIO_LO = 16'hDF00;
  localparam logic [15:0] UMD_RADIO_HI = 16'hDF3D;
  localparam logic [15:0] UMD_I2S_LO = 16'hDF40;
  localparam logic [15:0] UMD_I2S_HI = 16'hDF48;
  localparam logic [15:0] UMD_SFR_LO = 16'hDF80;
  localparam logic [15:0] UMD_SFR_HI = 16'hDFFF;
  localparam logic [15:0] UMD_USB_LO = 16'hDE00;
  localparam logic [15:0] UMD_USB_HI = 16'hDE3F;

  // ==========================================================================
  // DATA / special function space layout
  localparam logic [7:0] UMD_DATA_DIRECT_TOP = 8'h7F;
  localparam logic [7:0] UMD_BANKS_TOP = 8'h2F;
  localparam logic [7:0] UMD_BITADDR_LO = 8'h20;
  localparam logic [7:0] UMD_BITADDR_HI = 8'h2F;
  localparam logic [6:0] UMD_SFR_BIT_MASK = 7'h07;

  // ==========================================================================
  // Reset values
  localparam logic UMD_CACHE_DIS_RST = 1'b0;

  typedef enum logic [2:0] {
    UMD_TGT_NONE,
    UMD_TGT_FLASH,
    UMD_TGT_SRAM,
    UMD_TGT_DATA,
    UMD_TGT_RADIO,
    UMD_TGT_I2S,
    UMD_TGT_SFR,
    UMD_TGT_USB
  } umd_target_t;

endpackage : umd_pkg

// ===== core/umd_decoder.sv
/*
  Unified memory map decoder: one registered decode of each access into
  at most one target select, with flash write blocking, cache steering,
  DATA / special function space attribute outputs and retention marking.
  Assumes the CPU arbitrates code fetch against external data itself and
  holds request signals stable; all inputs come from logic on i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Flash from zero to variant-dependent end.
// - SRAM decoded at top, starting 0xF000.
// - Smaller variants leave SRAM holes unimplemented.
// - Largest variant region 0xFDA2 loses contents deep.
// - DATA space mirrored at 0xFF00-0xFFFF.
// - 0xDF00-0xDF3D selects radio registers.
// - 0xDF40-0xDF48 selects I2S registers.
// - 0xDF80-0xDFFF selects peripheral special registers.
// - CPU-internal special registers never reached via map.
// - USB window only on USB variant.
// - Code fetches decode like external data.
// - External-data writes never alter flash.
// - Unimplemented addresses give undefined results.
// - Upper DATA half only indirectly reachable.
// - Register banks low; 0x20-0x2F bit addressable.
// - Seven-bit special space; multiples of eight bitwise.
// - Code prefetch waits during external-data access.
// - Flash fetches cached unless cache disabled.
// - DATA storage retained in all power modes.
// - Flash information page selected only via debug configuration.
// - SRAM undefined after power-on, never initialised.
module umd_decoder (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [1:0] i_variant,
  input wire logic i_usb_present,
  input wire logic i_req_valid,
  input wire logic [15:0] i_req_addr,
  input wire logic i_req_write,
  input wire logic i_req_is_code,
  input wire logic i_req_is_dma,
  input wire logic i_sfr_in_core,
  input wire logic i_cache_dis_wr,
  input wire logic i_cache_dis_val,
  input wire logic i_dbg_info_page_sel,
  input wire logic i_data_direct,
  input wire logic [7:0] i_data_addr,
  input wire logic [6:0] i_sfr_addr,
  output logic o_sel_valid,
  output umd_pkg::umd_target_t o_target,
  output logic [15:0] o_offset,
  output logic o_write_en,
  output logic o_via_cache,
  output logic o_volatile_deep,
  output logic o_prefetch_stall,
  output logic o_cache_dis,
  output logic o_flash_info_page,
  output logic o_data_to_sfr,
  output logic o_data_bit_ok,
  output logic o_sfr_bit_ok,
  output logic o_data_bank_area
);
  import umd_pkg::*;

  // ==========================================================================
  // Combinational decode
  logic [15:0] flash_end;
  logic [15:0] hole_lo;
  logic has_hole;
  umd_target_t tgt_d;
  logic [15:0] base_d;

  always_comb begin
    unique case (i_variant)
      UMD_VAR_SMALL: flash_end = UMD_FLASH_END_SMALL;
      UMD_VAR_MID: flash_end = UMD_FLASH_END_MID;
      default: flash_end = UMD_FLASH_END_LARGE;
    endcase
    has_hole = (i_variant == UMD_VAR_SMALL) || (i_variant == UMD_VAR_MID);
    hole_lo = (i_variant == UMD_VAR_SMALL) ? UMD_HOLE_LO_SMALL : UMD_HOLE_LO_MID;
  end

  // Same map for code fetch, data, CPU and DMA; priority gives one target
  always_comb begin
    tgt_d = UMD_TGT_NONE;
    base_d = 16'h0000;
    if (i_req_addr <= flash_end) begin
      tgt_d = UMD_TGT_FLASH;
    end else if (i_req_addr >= UMD_DATA_LO) begin
      tgt_d = UMD_TGT_DATA;
      base_d = UMD_DATA_LO;
    end else if (i_req_addr >= UMD_SRAM_BASE) begin
      if (!(has_hole && i_req_addr >= hole_lo && i_req_addr <= UMD_HOLE_HI)) begin
        tgt_d = UMD_TGT_SRAM;
        base_d = UMD_SRAM_BASE;
      end
    end else if (i_req_addr >= UMD_RADIO_LO && i_req_addr <= UMD_RADIO_HI) begin
      tgt_d = UMD_TGT_RADIO;
      base_d = UMD_RADIO_LO;
    end else if (i_req_addr >= UMD_I2S_LO && i_req_addr <= UMD_I2S_HI) begin
      tgt_d = UMD_TGT_I2S;
      base_d = UMD_I2S_LO;
    end else if (i_req_addr >= UMD_SFR_LO && i_req_addr <= UMD_SFR_HI) begin
      if (!i_sfr_in_core) begin
        tgt_d = UMD_TGT_SFR;
        base_d = UMD_SFR_LO;
      end
    end else if (i_req_addr >= UMD_USB_LO && i_req_addr <= UMD_USB_HI) begin
      if (i_usb_present) begin
        tgt_d = UMD_TGT_USB;
        base_d = UMD_USB_LO;
      end
    end
  end

  // ==========================================================================
  // Registered select
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_sel_valid <= 1'b0;
      o_target <= UMD_TGT_NONE;
      o_offset <= 16'h0000;
      o_write_en <= 1'b0;
      o_via_cache <= 1'b0;
      o_volatile_deep <= 1'b0;
    end else if (i_clk_en) begin
      o_sel_valid <= i_req_valid && (tgt_d != UMD_TGT_NONE);
      o_target <= i_req_valid ? tgt_d : UMD_TGT_NONE;
      o_offset <= i_req_addr - base_d;
      // Flash never takes an ordinary write; SRAM needs no init either
      o_write_en <= i_req_valid && i_req_write && (tgt_d != UMD_TGT_FLASH)
                    && (tgt_d != UMD_TGT_NONE);
      o_via_cache <= i_req_valid && i_req_is_code && !i_req_is_dma
                     && (tgt_d == UMD_TGT_FLASH) && !o_cache_dis;
      // DATA mirror never marked volatile
      o_volatile_deep <= i_req_valid && (i_variant == UMD_VAR_LARGE)
                         && (tgt_d == UMD_TGT_SRAM) && (i_req_addr >= UMD_VOLATILE_LO)
                         && (i_req_addr <= UMD_VOLATILE_HI);
    end
  end

  // Shared code/data bus: stall prefetch while CPU does external data
  assign o_prefetch_stall = i_req_valid && !i_req_is_code && !i_req_is_dma;

  // ==========================================================================
  // Cache disable and information page select
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_cache_dis <= UMD_CACHE_DIS_RST;
    end else if (i_clk_en && i_cache_dis_wr) begin
      o_cache_dis <= i_cache_dis_val;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_flash_info_page <= 1'b0;
    end else if (i_clk_en) begin
      o_flash_info_page <= i_dbg_info_page_sel;
    end
  end

  // ==========================================================================
  // DATA and special function space attributes
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_data_to_sfr <= 1'b0;
      o_data_bit_ok <= 1'b0;
      o_sfr_bit_ok <= 1'b0;
      o_data_bank_area <= 1'b0;
    end else if (i_clk_en) begin
      o_data_to_sfr <= i_data_direct && (i_data_addr > UMD_DATA_DIRECT_TOP);
      o_data_bit_ok <= (i_data_addr >= UMD_BITADDR_LO)
                       && (i_data_addr <= UMD_BITADDR_HI);
      o_data_bank_area <= i_data_addr <= UMD_BANKS_TOP;
      o_sfr_bit_ok <= (i_sfr_addr & UMD_SFR_BIT_MASK) == 7'h00;
    end
  end

  // ==========================================================================
  // Checks
  chk_flash_no_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_req_write && i_req_addr <= flash_end |=> !o_write_en)
    else $error("write enabled toward flash");

  chk_radio_select: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_req_addr >= UMD_RADIO_LO && i_req_addr <= UMD_RADIO_HI
    |=> o_sel_valid && o_target == UMD_TGT_RADIO)
    else $error("radio window not selected");

  chk_i2s_select: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_req_addr >= UMD_I2S_LO && i_req_addr <= UMD_I2S_HI
    |=> o_target == UMD_TGT_I2S)
    else $error("i2s window not selected");

  chk_core_sfr_hidden: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_sfr_in_core |=> o_target != UMD_TGT_SFR)
    else $error("core special register reached through map");

  chk_usb_absent: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && !i_usb_present |=> o_target != UMD_TGT_USB)
    else $error("usb selected without usb");

  chk_data_mirror: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_req_addr >= UMD_DATA_LO
    |=> o_target == UMD_TGT_DATA && o_offset == $past(i_req_addr) - UMD_DATA_LO)
    else $error("data mirror misdecoded");

  chk_sram_hole: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_variant == UMD_VAR_SMALL && i_req_addr >= UMD_HOLE_LO_SMALL
    && i_req_addr <= UMD_HOLE_HI |=> !o_sel_valid)
    else $error("hole decoded as sram");

  chk_cache_bypass: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && o_cache_dis |=> !o_via_cache)
    else $error("fetch cached while disabled");

  chk_direct_upper: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_data_direct && i_data_addr[7] |=> o_data_to_sfr)
    else $error("upper direct not sent to special space");

  chk_flash_select: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_req_addr <= flash_end
    |=> o_sel_valid && o_target == UMD_TGT_FLASH && o_offset == $past(i_req_addr))
    else $error("flash window not selected");

  chk_flash_end: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_variant == UMD_VAR_SMALL && i_req_addr > UMD_FLASH_END_SMALL
    && i_req_addr <= UMD_FLASH_END_LARGE |=> !o_sel_valid)
    else $error("flash decoded past its end");

  chk_sram_select: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_variant == UMD_VAR_LARGE && i_req_addr >= UMD_SRAM_BASE
    && i_req_addr < UMD_DATA_LO
    |=> o_target == UMD_TGT_SRAM && o_offset == $past(i_req_addr) - UMD_SRAM_BASE)
    else $error("sram window not selected");

  chk_mid_hole: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_variant == UMD_VAR_MID && i_req_addr >= UMD_HOLE_LO_MID
    && i_req_addr <= UMD_HOLE_HI |=> !o_sel_valid)
    else $error("mid hole decoded as sram");

  chk_volatile_mark: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_variant == UMD_VAR_LARGE && i_req_addr >= UMD_VOLATILE_LO
    && i_req_addr <= UMD_VOLATILE_HI |=> o_volatile_deep)
    else $error("volatile sram not marked");

  chk_retained_area: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && (i_variant != UMD_VAR_LARGE || i_req_addr < UMD_VOLATILE_LO
    || i_req_addr > UMD_VOLATILE_HI) |=> !o_volatile_deep)
    else $error("retained area marked volatile");

  chk_sfr_select: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && !i_sfr_in_core && i_req_addr >= UMD_SFR_LO
    && i_req_addr <= UMD_SFR_HI
    |=> o_target == UMD_TGT_SFR && o_offset == $past(i_req_addr) - UMD_SFR_LO)
    else $error("special window not selected");

  chk_usb_select: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_usb_present && i_req_addr >= UMD_USB_LO
    && i_req_addr <= UMD_USB_HI |=> o_target == UMD_TGT_USB)
    else $error("usb window not selected");

  chk_code_from_sram: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_req_is_code && i_variant == UMD_VAR_LARGE
    && i_req_addr >= UMD_SRAM_BASE && i_req_addr < UMD_DATA_LO
    |=> o_target == UMD_TGT_SRAM && !o_via_cache)
    else $error("code fetch from sram misdecoded");

  chk_unimpl_none: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_req_valid && i_req_addr > UMD_FLASH_END_LARGE && i_req_addr < UMD_USB_LO
    |=> !o_sel_valid && !o_write_en)
    else $error("unimplemented address selected");

  chk_one_target: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_sel_valid == (o_target != UMD_TGT_NONE))
    else $error("select and target disagree");

  chk_idle_none: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && !i_req_valid |=> !o_sel_valid && !o_write_en && !o_via_cache)
    else $error("idle cycle selected a target");

  chk_prefetch_stall: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_req_valid && !i_req_is_code && !i_req_is_dma |-> o_prefetch_stall)
    else $error("prefetch not stalled for data access");

  chk_cache_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_cache_dis_wr |=> o_cache_dis == $past(i_cache_dis_val))
    else $error("cache disable not loaded");

  chk_info_page: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en |=> o_flash_info_page == $past(i_dbg_info_page_sel))
    else $error("info page select not followed");

  chk_data_bits: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_data_addr >= UMD_BITADDR_LO && i_data_addr <= UMD_BITADDR_HI
    |=> o_data_bit_ok && o_data_bank_area)
    else $error("bit area not flagged");

  chk_direct_lower: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && !i_data_addr[7] |=> !o_data_to_sfr)
    else $error("lower direct sent to special space");

  chk_sfr_bits: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_clk_en && i_sfr_addr[2:0] == 3'h0 |=> o_sfr_bit_ok)
    else $error("bit special register not flagged");

endmodule : umd_decoder

`default_nettype wire

// ===== tb/umd_req_model.sv
/*
  Requester model for the decoder: a CPU or DMA access source.
  Assumes the bench hands it one access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module umd_req_model (
  input wire logic i_want,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_code,
  input wire logic i_dma,
  output logic o_req_valid,
  output logic [15:0] o_req_addr,
  output logic o_req_write,
  output logic o_req_is_code,
  output logic o_req_is_dma
);
  // ======
  // Access issue; idle address is scrambled
  always_comb begin
    o_req_valid = i_want;
    o_req_addr = i_want ? i_addr : ~i_addr;
    o_req_write = i_wr & ~i_code;
    o_req_is_code = i_code & ~i_dma;
    o_req_is_dma = i_dma;
  end
endmodule : umd_req_model
`default_nettype wire

// ===== tb/testbench.sv
/*
  Bench for the unified map decoder: corner and random accesses per variant.
  Assumes a 125 MHz clock and one access per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
  import umd_pkg::*;
  logic i_sys_clk = 0, i_reset = 1, i_clk_en = 1, i_usb_present = 0, i_sfr_in_core = 0;
  logic i_cache_dis_wr = 0, i_cache_dis_val = 0, i_dbg_info_page_sel = 0, i_data_direct = 0;
  logic [1:0] i_variant = 0;
  logic [7:0] i_data_addr = 0;
  logic [6:0] i_sfr_addr = 0;
  logic w_want = 0, w_wr = 0, w_code = 0, w_dma = 0, rv, rw, rc, rd;
  logic [15:0] w_addr = 0, ra, o_offset;
  logic o_sel_valid, o_write_en, o_via_cache, o_volatile_deep, o_prefetch_stall, o_cache_dis;
  logic o_flash_info_page, o_data_to_sfr, o_data_bit_ok, o_sfr_bit_ok, o_data_bank_area;
  umd_target_t o_target;
  logic [18:0] x_dec = 0;
  logic [9:0] x = 0;
  int fail_count = 0, samples_checked = 0, seed = 97, k;
  logic [15:0] corners [28] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000, 16'h7FFF,
    16'h8000, 16'hDE00, 16'hDE3F, 16'hDE40, 16'hDF00, 16'hDF3D, 16'hDF3E, 16'hDF40, 16'hDF48,
    16'hDF49, 16'hDF80, 16'hDFFF, 16'hF000, 16'hF2FF, 16'hF300, 16'hF6FF, 16'hF700, 16'hFDA1,
    16'hFDA2, 16'hFEFF, 16'hFF00, 16'hFFFF};

  always #4 i_sys_clk = ~i_sys_clk;

  umd_req_model i_umd_req_model (.i_want(w_want), .i_addr(w_addr), .i_wr(w_wr),
    .i_code(w_code), .i_dma(w_dma), .o_req_valid(rv), .o_req_addr(ra), .o_req_write(rw),
    .o_req_is_code(rc), .o_req_is_dma(rd));
  umd_decoder i_umd_decoder (.i_sys_clk, .i_reset, .i_clk_en, .i_variant, .i_usb_present,
    .i_req_valid(rv), .i_req_addr(ra), .i_req_write(rw), .i_req_is_code(rc),
    .i_req_is_dma(rd), .i_sfr_in_core, .i_cache_dis_wr, .i_cache_dis_val,
    .i_dbg_info_page_sel, .i_data_direct, .i_data_addr, .i_sfr_addr, .o_sel_valid, .o_target,
    .o_offset, .o_write_en, .o_via_cache, .o_volatile_deep, .o_prefetch_stall, .o_cache_dis,
    .o_flash_info_page, .o_data_to_sfr, .o_data_bit_ok, .o_sfr_bit_ok, .o_data_bank_area);

  // ======
  // Expected target and offset
  function automatic logic [18:0] exp_dec(logic [15:0] a, logic [1:0] v, logic usb, logic cr);
    logic [15:0] fe;
    logic [15:0] hl;
    fe = v == 2'h0 ? 16'h1FFF : v == 2'h1 ? 16'h3FFF : 16'h7FFF;
    hl = v == 2'h0 ? 16'hF300 : v == 2'h1 ? 16'hF700 : 16'hFF00;
    if (a <= fe) return {3'h1, a};
    if (a >= 16'hFF00) return {3'h3, a - 16'hFF00};
    if (a >= 16'hF000 && a < hl) return {3'h2, a - 16'hF000};
    if (a >= 16'hDF00 && a <= 16'hDF3D) return {3'h4, a - 16'hDF00};
    if (a >= 16'hDF40 && a <= 16'hDF48) return {3'h5, a - 16'hDF40};
    if (a >= 16'hDF80 && a <= 16'hDFFF && !cr) return {3'h6, a - 16'hDF80};
    if (usb && a >= 16'hDE00 && a <= 16'hDE3F) return {3'h7, a - 16'hDE00};
    return 19'h00000;
  endfunction : exp_dec

  task automatic check_all();
    `CHK("sel", x[0], o_sel_valid)
    `CHK("target", x_dec[18:16], 3'(o_target))
    if (x[0]) `CHK("offset", x_dec[15:0], o_offset)
    `CHK("wr_en", x[1], o_write_en)
    `CHK("via_cache", x[2], o_via_cache)
    `CHK("volatile", x[3], o_volatile_deep)
    `CHK("cache_dis", x[4], o_cache_dis)
    `CHK("info_page", x[5], o_flash_info_page)
    `CHK("to_sfr", x[6], o_data_to_sfr)
    `CHK("data_bit", x[7], o_data_bit_ok)
    `CHK("sfr_bit", x[8], o_sfr_bit_ok)
    `CHK("banks", x[9], o_data_bank_area)
  endtask : check_all

  task automatic step(input logic [15:0] a);
    logic [31:0] r;
    logic [18:0] e;
    r = $random(seed);
    {i_clk_en, w_wr, w_code, w_dma, i_sfr_in_core, i_data_direct, i_data_addr, i_sfr_addr,
      i_dbg_info_page_sel, i_cache_dis_val, i_cache_dis_wr, w_want} = r[24:0];
    i_clk_en = i_clk_en | r[25] | r[26];
    w_addr = a;
    #1;
    `CHK("stall", rv & ~rc & ~rd, o_prefetch_stall)
    if (i_clk_en) begin
      e = rv ? exp_dec(ra, i_variant, i_usb_present, i_sfr_in_core) : 19'h00000;
      x_dec = e;
      x[0] = e[18:16] != 3'h0;
      x[1] = x[0] && rw && e[18:16] != 3'h1;
      x[2] = rc && !rd && e[18:16] == 3'h1 && !x[4];
      x[3] = e[18:16] == 3'h2 && i_variant == 2'h2 && ra >= 16'hFDA2 && ra <= 16'hFEFF;
      if (i_cache_dis_wr) x[4] = i_cache_dis_val;
      x[5] = i_dbg_info_page_sel;
      x[6] = i_data_direct && i_data_addr > 8'h7F;
      x[7] = i_data_addr >= 8'h20 && i_data_addr <= 8'h2F;
      x[8] = i_sfr_addr[2:0] == 3'h0;
      x[9] = i_data_addr <= 8'h2F;
    end
    @(posedge i_sys_clk);
    #1;
    check_all();
  endtask : step

  task automatic report_and_stop();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ======
  // Main sequence: reset, then each variant with and without USB
  initial begin
    for (k = 0; k < 6; k++) begin
      i_reset = 1;
      i_clk_en = 1;
      i_variant = 2'(k % 3);
      i_usb_present = k > 2;
      repeat (k == 0 ? 20 : 2) @(posedge i_sys_clk);
      #1;
      i_reset = 0;
      x = 10'h000;
      x_dec = 19'h00000;
      check_all();
      foreach (corners[j]) step(corners[j]);
      repeat (150) step(16'($random(seed)));
    end
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
